// [logic/ddrpd_pkg.sv]
// Shared constants, command codes and latency helpers for the power-down / ODT pair.
// Assumes one 20 MHz clock on both ends and a link sampled on its rising edge.
//
// Overview of operation
// - Enter power-down on CKE low with NOP
// - No CKE low during MRS/ZQ/DLL lock/bursts
// - Activate/precharge/refresh finish before low power
// - Banks closed: precharge, else active power-down
// - Reset DLL after exit if unlocked entry
// - Receivers off after command-path disable delay
// - Slow exit: DLL off, longer exit wait (here both exit waits round up to one clock)
// - Fast exit: DLL kept, plain exit wait
// - In power-down hold CKE low, reset high
// - Reset low in power-down goes to reset
// - CKE low and high each for min pulse
// - Power-down at most nine refresh intervals
// - Exit on CKE high with NOP, then wait
// - ODT switches data termination, strobe pair optional
// - Self-refresh or disabled termination ignores ODT
// - Termination enabled when nominal or write bits nonzero
// - ODT low off, high on, no decoding
// - Synchronous ODT whenever the DLL runs
// - DLL off: controller keeps termination disabled
// - ODT latency is write latency minus two
// - Hold ODT high after assert or write
// - Short hold four, long hold six clocks
// - ODT low around reads, off before preamble
// - Termination returns only when drivers stop
`default_nettype none
package ddrpd_pkg;
	typedef enum logic [3:0] {
		CMD_NOP = 4'h0, CMD_DES = 4'h1, CMD_ACT = 4'h2, CMD_PRE = 4'h3,
		CMD_REF = 4'h4, CMD_MRS = 4'h5, CMD_RD = 4'h6, CMD_WR = 4'h7,
		CMD_ZQ = 4'h8, CMD_MPR = 4'h9
	} ddrpd_cmd_t;

	localparam int CLK_PERIOD_NS = 50;
	localparam int POWERDOWN_EXIT_DELAY_NS = 24;
	localparam int POWERDOWN_EXIT_DLL_DELAY_NS = 24;
	localparam int COMMAND_PATH_DISABLE_DELAY_NS = 10;
	localparam int CLOCK_ENABLE_MIN_PULSE_NS = 5;
	localparam int AVERAGE_REFRESH_INTERVAL_NS = 7800;
	localparam int PD_MAX_REFRESH_INTERVALS = 9;
	localparam int EXIT_CYC = (POWERDOWN_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_DLL_CYC =
		(POWERDOWN_EXIT_DLL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CPDED_CYC =
		(COMMAND_PATH_DISABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CKE_MIN_CYC = (CLOCK_ENABLE_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PD_MAX_CYC =
		PD_MAX_REFRESH_INTERVALS * AVERAGE_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
	localparam int TERMINATION_HOLD_SHORT = 4;
	localparam int TERMINATION_HOLD_LONG = 6;
	localparam int BURST_CLOCKS = 4;

	// Mode register fields
	localparam int MR0_CL_LO = 4;
	localparam int MR0_DLL_RESET_BIT = 8;
	localparam int MR0_DLL_FREEZE_SELECT_BIT = 12;
	localparam int MR1_DLL_DISABLE_BIT = 0;
	localparam int MR1_AL_LO = 3;
	localparam int MR1_STROBE_TERMINATION_ENABLE_BIT = 11;
	localparam int MR2_CWL_LO = 3;
	localparam int ADDR_PRE_ALL_BIT = 10;
	localparam int ADDR_BURST8_BIT = 12;
	localparam logic [15:0] MR_RESET_VALUE = 16'h0000;
	localparam logic [4:0] CL_BASE = 5'h04;
	localparam logic [4:0] CWL_BASE = 5'h05;

	// Controller register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_PD_REQ = 0;
	localparam int CTRL_ODT_REQ = 1;

	function automatic logic [4:0] ddrpd_al(input logic [15:0] mr0, input logic [15:0] mr1);
		logic [4:0] cl;
		cl = 5'(mr0[MR0_CL_LO +: 3]) + CL_BASE;
		case (mr1[MR1_AL_LO +: 2])
			2'h1: return cl - 5'h01;
			2'h2: return cl - 5'h02;
			default: return 5'h00;
		endcase
	endfunction

	function automatic logic [4:0] ddrpd_rl(input logic [15:0] mr0, input logic [15:0] mr1);
		return 5'(mr0[MR0_CL_LO +: 3]) + CL_BASE + ddrpd_al(mr0, mr1);
	endfunction

	function automatic logic [4:0] ddrpd_lat(input logic [15:0] mr0, input logic [15:0] mr1,
		input logic [15:0] mr2);
		return 5'(mr2[MR2_CWL_LO +: 3]) + CWL_BASE + ddrpd_al(mr0, mr1) - 5'h02;
	endfunction

	function automatic logic [2:0] ddrpd_rtt_nom(input logic [15:0] mr1);
		return {mr1[9], mr1[6], mr1[2]};
	endfunction
endpackage
`default_nettype wire

// [logic/ddrpd_if.sv]
// Link between the memory controller end and the DRAM end.
// Assumes both ends sample every signal on the same rising clock edge.
`timescale 1ns/100ps
`default_nettype none
interface ddrpd_if;
	logic cke;
	logic odt;
	logic reset_n;
	ddrpd_pkg::ddrpd_cmd_t cmd;
	logic [2:0] bank;
	logic [15:0] addr;
	logic term_on;
	logic termination_strobe_pair_term;
	logic dq_drive;
	logic [2:0] rtt_sel;
	modport dev (input cke, odt, reset_n, cmd, bank, addr,
		output term_on, termination_strobe_pair_term, dq_drive, rtt_sel);
	modport ctl (output cke, odt, reset_n, cmd, bank, addr,
		input term_on, termination_strobe_pair_term, dq_drive, rtt_sel);
endinterface
`default_nettype wire

// [logic/ddrpd_device.sv]
// DRAM end: power-down sequencing, DLL state and termination control.
// Assumes link inputs synchronous to clock; the pin reset is sampled, arst_n is system reset.
`timescale 1ns/100ps
`default_nettype none
module ddrpd_device #(
	parameter int OP_CYC = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Link
	ddrpd_if.dev lnk,
	// Status
	output logic low_power,
	output logic dll_running
);
	import ddrpd_pkg::*;

	typedef enum logic [2:0] {
		ST_ON = 3'h0, ST_ENTER = 3'h1, ST_PD_ACT = 3'h2, ST_PD_FAST = 3'h3,
		ST_PD_SLOW = 3'h4, ST_SREF = 3'h5, ST_EXIT = 3'h6, ST_RST = 3'h7
	} ddrpd_dstate_t;

	ddrpd_dstate_t state_r, state_nxt;
	logic [15:0] mr0_r, mr1_r, mr2_r;
	logic [7:0] bank_open_r;
	logic [3:0] busy_r;
	logic [7:0] xp_r, xpdll_r, cpd_r;
	logic [31:0] odt_pipe_r, rd_pipe_r;
	logic term_r, termination_strobe_pair_r, drive_r, low_power_r, dll_r;
	logic [2:0] rtt_r;
	logic nop, in_pd, rx_off, cmd_ok, dll_ok, acc, dll_on, drive_nxt, term_nxt, term_en;
	logic [4:0] lat, rl;

	assign nop = (lnk.cmd == CMD_NOP) || (lnk.cmd == CMD_DES);
	assign in_pd = (state_r == ST_PD_ACT) || (state_r == ST_PD_FAST) || (state_r == ST_PD_SLOW);
	assign rx_off = (cpd_r == 8'(CPDED_CYC));
	assign cmd_ok = (state_r == ST_ON) || ((state_r == ST_EXIT) && (xp_r == 8'h00));
	assign dll_ok = cmd_ok && ((state_r != ST_EXIT) || (xpdll_r == 8'h00));
	assign acc = lnk.cke && lnk.reset_n && cmd_ok && !nop && ((lnk.cmd != CMD_RD) || dll_ok);
	assign lat = ddrpd_lat(mr0_r, mr1_r, mr2_r);
	assign rl = ddrpd_rl(mr0_r, mr1_r);
	// DLL off in slow power-down, self-refresh and reset, or when MR1 disables it
	assign dll_on = !mr1_r[MR1_DLL_DISABLE_BIT] && (state_r != ST_PD_SLOW)
		&& (state_r != ST_SREF) && (state_r != ST_RST);
	// enabled by nominal or write bits
	assign term_en = (ddrpd_rtt_nom(mr1_r) != 3'h0) || (mr2_r[10:9] != 2'h0);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_ON, ST_EXIT: begin
				if (!lnk.cke && nop)
					state_nxt = ST_ENTER;
				else if (!lnk.cke && (lnk.cmd == CMD_REF))
					state_nxt = ST_SREF;
				else if ((state_r == ST_EXIT) && (xp_r == 8'h00) && (xpdll_r == 8'h00))
					state_nxt = ST_ON;
			end
			ST_ENTER: begin
				if (lnk.cke && (nop || rx_off))
					state_nxt = ST_EXIT;
				else if (busy_r == 4'h0) begin
					if (bank_open_r != 8'h00)
						state_nxt = ST_PD_ACT;
					else if (mr0_r[MR0_DLL_FREEZE_SELECT_BIT])
						state_nxt = ST_PD_FAST;
					else
						state_nxt = ST_PD_SLOW;
				end
			end
			ST_PD_ACT, ST_PD_FAST, ST_PD_SLOW: begin
				if (lnk.cke && (nop || rx_off))
					state_nxt = ST_EXIT;
			end
			ST_SREF: begin
				if (lnk.cke)
					state_nxt = ST_EXIT;
			end
			ST_RST: begin
				if (lnk.reset_n)
					state_nxt = ST_ON;
			end
		endcase
		if (!lnk.reset_n)
			state_nxt = ST_RST;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			state_r <= ST_RST;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			xp_r <= 8'h00;
			xpdll_r <= 8'h00;
		end else if ((state_nxt == ST_EXIT) && (state_r != ST_EXIT)) begin
			xp_r <= 8'(EXIT_CYC);
			xpdll_r <= ((state_r == ST_PD_SLOW) || (state_r == ST_SREF)) ? 8'(EXIT_DLL_CYC) : 8'h00;
		end else begin
			xp_r <= (xp_r != 8'h00) ? xp_r - 8'h01 : 8'h00;
			xpdll_r <= (xpdll_r != 8'h00) ? xpdll_r - 8'h01 : 8'h00;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			cpd_r <= 8'h00;
		else if (!(in_pd || (state_r == ST_ENTER)) || (state_nxt == ST_EXIT))
			cpd_r <= 8'h00;
		else if (!rx_off)
			cpd_r <= cpd_r + 8'h01;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			busy_r <= 4'h0;
		else if (acc && ((lnk.cmd == CMD_ACT) || (lnk.cmd == CMD_PRE) || (lnk.cmd == CMD_REF)))
			busy_r <= 4'(OP_CYC);
		else if (busy_r != 4'h0)
			busy_r <= busy_r - 4'h1;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			bank_open_r <= 8'h00;
		else if (state_r == ST_RST)
			bank_open_r <= 8'h00;
		else if (acc && (lnk.cmd == CMD_ACT))
			bank_open_r[lnk.bank] <= 1'b1;
		else if (acc && (lnk.cmd == CMD_PRE)) begin
			if (lnk.addr[ADDR_PRE_ALL_BIT])
				bank_open_r <= 8'h00;
			else
				bank_open_r[lnk.bank] <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mr0_r <= MR_RESET_VALUE;
			mr1_r <= MR_RESET_VALUE;
			mr2_r <= MR_RESET_VALUE;
		end else if (state_r == ST_RST) begin
			mr0_r <= MR_RESET_VALUE;
			mr1_r <= MR_RESET_VALUE;
			mr2_r <= MR_RESET_VALUE;
		end else if (acc && (lnk.cmd == CMD_MRS)) begin
			if (lnk.bank == 3'h0)
				mr0_r <= lnk.addr;
			if (lnk.bank == 3'h1)
				mr1_r <= lnk.addr;
			if (lnk.bank == 3'h2)
				mr2_r <= lnk.addr;
		end
	end

	// Pipes stay short: latencies here never pass 24 clocks
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			odt_pipe_r <= 32'h0000_0000;
			rd_pipe_r <= 32'h0000_0000;
		end else begin
			odt_pipe_r <= {odt_pipe_r[30:0], lnk.odt};
			rd_pipe_r <= {rd_pipe_r[30:0], acc && (lnk.cmd == CMD_RD)};
		end
	end

	always_comb begin
		drive_nxt = |rd_pipe_r[rl - 5'h01 +: BURST_CLOCKS];
		if (dll_on)
			term_nxt = odt_pipe_r[lat - 5'h01];
		else
			term_nxt = lnk.odt;
		if (!term_en || (state_r == ST_SREF) || (state_r == ST_RST))
			term_nxt = 1'b0;
		if (drive_nxt)
			term_nxt = 1'b0;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			term_r <= 1'b0;
			termination_strobe_pair_r <= 1'b0;
			drive_r <= 1'b0;
			rtt_r <= 3'h0;
			low_power_r <= 1'b0;
			dll_r <= 1'b0;
		end else begin
			term_r <= term_nxt;
			termination_strobe_pair_r <= term_nxt && mr1_r[MR1_STROBE_TERMINATION_ENABLE_BIT];
			drive_r <= drive_nxt;
			rtt_r <= (ddrpd_rtt_nom(mr1_r) != 3'h0) ? ddrpd_rtt_nom(mr1_r) : {1'b0, mr2_r[10:9]};
			low_power_r <= (in_pd || (state_r == ST_SREF)) && (busy_r == 4'h0);
			dll_r <= dll_on;
		end
	end

	assign lnk.term_on = term_r;
	assign lnk.termination_strobe_pair_term = termination_strobe_pair_r;
	assign lnk.dq_drive = drive_r;
	assign lnk.rtt_sel = rtt_r;
	assign low_power = low_power_r;
	assign dll_running = dll_r;
endmodule
`default_nettype wire

// [logic/ddrpd_ctrl.sv]
// Controller end: AHB-Lite register slave driving CKE, ODT and commands.
// Assumes a single AHB-Lite master on clock; link sampled by the DRAM end.
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ddrpd_ctrl #(
	parameter int OP_BUSY = 8,
	parameter int DLL_LOCK_CYC = 512
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Link
	ddrpd_if.ctl lnk
);
	import ddrpd_pkg::*;

	typedef enum logic [1:0] {C_RUN = 2'h0, C_PD = 2'h1, C_WAIT = 2'h2} ddrpd_cstate_t;

	ddrpd_cstate_t cs_r;
	logic wr_ph_r;
	logic [7:0] adr_r;
	logic [1:0] ctrl_r;
	logic pend_r, relock_r, locked_r, cke_r, odt_r;
	logic [22:0] cmdw_r;
	logic [15:0] mr0_r, mr1_r, mr2_r, addr_r;
	logic [7:0] bank_open_r, busy_r, cke_cnt_r, wait_r, rdg_r;
	logic [10:0] pd_cnt_r;
	logic [9:0] lock_r;
	logic [2:0] hold_r, bank_r;
	ddrpd_cmd_t cmd_r, icmd;
	logic [31:0] rdata_r;
	logic issue, odt_nxt, rd_want, go_pd;
	logic arst_n_q;
	logic [2:0] ibank;
	logic [15:0] iaddr;

	// AHB address phase and registered read data
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_ph_r <= 1'b0;
			adr_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else if (hready) begin
			wr_ph_r <= hsel && htrans[1] && hwrite;
			adr_r <= haddr[7:0];
			unique case (haddr[7:0])
				REG_CTRL: rdata_r <= {30'h0, ctrl_r};
				REG_CMD: rdata_r <= {cmdw_r[22:7], 9'h000, cmdw_r[6:0]};
				REG_STATUS: rdata_r <= {27'h0, cs_r == C_WAIT, lnk.term_on, locked_r, !cke_r, pend_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	assign icmd = relock_r ? CMD_MRS : ddrpd_cmd_t'(cmdw_r[3:0]);
	assign ibank = relock_r ? 3'h0 : cmdw_r[6:4];
	assign iaddr = relock_r ? (mr0_r | (16'h0001 << MR0_DLL_RESET_BIT)) : cmdw_r[22:7];
	assign rd_want = pend_r && (ddrpd_cmd_t'(cmdw_r[3:0]) == CMD_RD);
	assign issue = (cs_r == C_RUN) && cke_r && (relock_r || pend_r)
		&& ((icmd != CMD_RD) || (!odt_r && locked_r));
	assign go_pd = (cs_r == C_RUN) && ctrl_r[CTRL_PD_REQ] && !issue && !pend_r
		&& (busy_r == 8'h00) && (lock_r == 10'h000) && (cke_cnt_r == 8'h00);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= 2'h0;
			pend_r <= 1'b0;
			cmdw_r <= 23'h000000;
		end else begin
			if (wr_ph_r && (adr_r == REG_CTRL))
				ctrl_r <= hwdata[1:0];
			// A command written while one waits is dropped
			if (wr_ph_r && (adr_r == REG_CMD) && !pend_r) begin
				pend_r <= 1'b1;
				cmdw_r <= {hwdata[31:16], hwdata[6:0]};
			end else if (issue && !relock_r)
				pend_r <= 1'b0;
		end
	end

	// Command drive, shadows of the DRAM state
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmd_r <= CMD_NOP;
			bank_r <= 3'h0;
			addr_r <= 16'h0000;
			mr0_r <= MR_RESET_VALUE;
			mr1_r <= MR_RESET_VALUE;
			mr2_r <= MR_RESET_VALUE;
			bank_open_r <= 8'h00;
		end else begin
			cmd_r <= issue ? icmd : CMD_NOP;
			bank_r <= issue ? ibank : 3'h0;
			addr_r <= issue ? iaddr : 16'h0000;
			if (issue && (icmd == CMD_MRS) && (ibank == 3'h0))
				mr0_r <= iaddr;
			if (issue && (icmd == CMD_MRS) && (ibank == 3'h1))
				mr1_r <= iaddr;
			if (issue && (icmd == CMD_MRS) && (ibank == 3'h2))
				mr2_r <= iaddr;
			if (issue && (icmd == CMD_ACT))
				bank_open_r[ibank] <= 1'b1;
			if (issue && (icmd == CMD_PRE))
				bank_open_r <= iaddr[ADDR_PRE_ALL_BIT] ? 8'h00 : bank_open_r & ~(8'h01 << ibank);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			busy_r <= 8'h00;
		else if (issue && (icmd != CMD_REF))
			busy_r <= 8'(OP_BUSY);
		else if (busy_r != 8'h00)
			busy_r <= busy_r - 8'h01;
	end

	// DLL lock and relock after exit
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			lock_r <= 10'h000;
			locked_r <= 1'b0;
			relock_r <= 1'b0;
		end else begin
			if (issue && (icmd == CMD_MRS) && (ibank == 3'h0) && iaddr[MR0_DLL_RESET_BIT]) begin
				lock_r <= 10'(DLL_LOCK_CYC);
				locked_r <= 1'b0;
			end else if (lock_r != 10'h000) begin
				lock_r <= lock_r - 10'h001;
				locked_r <= (lock_r == 10'h001);
			end
			if (go_pd)
				relock_r <= !locked_r;
			else if (issue && relock_r)
				relock_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cs_r <= C_RUN;
			cke_r <= 1'b1;
			cke_cnt_r <= 8'h00;
			pd_cnt_r <= 11'h000;
			wait_r <= 8'h00;
		end else begin
			if (cke_cnt_r != 8'h00)
				cke_cnt_r <= cke_cnt_r - 8'h01;
			unique case (cs_r)
				C_RUN: if (go_pd) begin
					cs_r <= C_PD;
					cke_r <= 1'b0;
					cke_cnt_r <= 8'(CKE_MIN_CYC);
					pd_cnt_r <= 11'h000;
				end
				C_PD: begin
					pd_cnt_r <= pd_cnt_r + 11'h001;
					if ((cke_cnt_r == 8'h00) && (!ctrl_r[CTRL_PD_REQ]
						|| (pd_cnt_r >= 11'(PD_MAX_CYC - 1)))) begin
						cs_r <= C_WAIT;
						cke_r <= 1'b1;
						cke_cnt_r <= 8'(CKE_MIN_CYC);
						// slow exit waits the DLL delay
						wait_r <= ((bank_open_r == 8'h00) && !mr0_r[MR0_DLL_FREEZE_SELECT_BIT])
							? 8'(EXIT_DLL_CYC) : 8'(EXIT_CYC);
					end
				end
				C_WAIT: begin
					if (wait_r != 8'h00)
						wait_r <= wait_r - 8'h01;
					else
						cs_r <= C_RUN;
				end
				default: cs_r <= C_RUN;
			endcase
		end
	end

	always_comb begin
		odt_nxt = ctrl_r[CTRL_ODT_REQ] && !mr1_r[MR1_DLL_DISABLE_BIT] && locked_r
			&& (rdg_r == 8'h00) && !rd_want && (cs_r != C_WAIT);
		if (odt_r && (hold_r > 3'h1))
			odt_nxt = 1'b1;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			odt_r <= 1'b0;
			hold_r <= 3'h0;
			rdg_r <= 8'h00;
		end else begin
			odt_r <= odt_nxt;
			if (odt_nxt && !odt_r)
				hold_r <= 3'(TERMINATION_HOLD_SHORT);
			else if (issue && (icmd == CMD_WR) && odt_r)
				hold_r <= iaddr[ADDR_BURST8_BIT] ? 3'(TERMINATION_HOLD_LONG)
					: 3'(TERMINATION_HOLD_SHORT);
			else if (hold_r != 3'h0)
				hold_r <= hold_r - 3'h1;
			if (issue && (icmd == CMD_RD))
				rdg_r <= 8'(ddrpd_rl(mr0_r, mr1_r)) + 8'(BURST_CLOCKS + 1)
					- 8'(ddrpd_lat(mr0_r, mr1_r, mr2_r));
			else if (rdg_r != 8'h00)
				rdg_r <= rdg_r - 8'h01;
		end
	end

	assign lnk.cke = cke_r;
	assign lnk.odt = odt_r;
	assign lnk.reset_n = arst_n_q;
	assign lnk.cmd = cmd_r;
	assign lnk.bank = bank_r;
	assign lnk.addr = addr_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;

	// Pin reset released one edge after system reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			arst_n_q <= 1'b0;
		else
			arst_n_q <= 1'b1;
	end
endmodule
`default_nettype wire

// [tb/ddrpd_assertions.sv]
// Checker for the link between controller end and DRAM end.
// Assumes mode registers change only by MRS on the link; LAT matches them.
`timescale 1ns/100ps
`default_nettype none
module ddrpd_assertions #(
	parameter int LAT = 3
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Link
	input wire logic cke,
	input wire logic odt,
	input wire logic reset_n,
	input wire ddrpd_pkg::ddrpd_cmd_t cmd,
	input wire logic [2:0] bank,
	input wire logic [15:0] addr,
	input wire logic term_on,
	input wire logic termination_strobe_pair_term,
	input wire logic dq_drive,
	input wire logic [2:0] rtt_sel,
	// Device status
	input wire logic low_power,
	input wire logic dll_running
);
	import ddrpd_pkg::*;
	logic [15:0] mr1_r;
	logic [15:0] mr2_r;
	logic frz_r;
	logic open_r;
	logic [7:0] sync_r;
	logic nom_on;
	assign nom_on = |{mr1_r[9], mr1_r[6], mr1_r[2]};
	// Shadow mode bits; pin reset clears them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n || !reset_n) begin
			mr1_r <= 16'h0000;
			mr2_r <= 16'h0000;
			frz_r <= 1'b0;
		end else if (cke && cmd == CMD_MRS) begin
			if (bank == 3'h0) frz_r <= addr[MR0_DLL_FREEZE_SELECT_BIT];
			if (bank == 3'h1) mr1_r <= addr;
			if (bank == 3'h2) mr2_r <= addr;
		end
	end
	// Single open flag; enough since the bench only precharges all banks
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n || !reset_n)
			open_r <= 1'b0;
		else if (cke && cmd == CMD_ACT)
			open_r <= 1'b1;
		else if (cke && cmd == CMD_PRE)
			open_r <= 1'b0;
	end
	// Latency pipe is only trustworthy after more than LAT + 1 settled cycles
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			sync_r <= 8'h00;
		else if (!dll_running || !reset_n || !nom_on)
			sync_r <= 8'h00;
		else if (sync_r != 8'hFF)
			sync_r <= sync_r + 8'h01;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	a_pd_nop_only: assert property (!cke |-> cmd inside {CMD_NOP, CMD_DES})
		else $error("command issued with clock enable low");
	a_pd_entry: assert property ($fell(cke) |-> ##[1:12] (low_power || cke))
		else $error("no power-down after clock enable low");
	a_pd_exit: assert property ($rose(cke) |-> cmd inside {CMD_NOP, CMD_DES} ##[0:2] !low_power)
		else $error("power-down exit wrong");
	a_slow_dll_off: assert property (
		low_power && $past(low_power) && !open_r && !frz_r |-> !dll_running)
		else $error("dll running in slow power-down");
	a_fast_dll_on: assert property (
		low_power && $past(low_power) && (open_r || frz_r) && !mr1_r[0] |-> dll_running)
		else $error("dll stopped in fast power-down");
	a_reset_leaves_pd: assert property (!reset_n |-> ##[1:2] !low_power)
		else $error("power-down held in pin reset");
	a_term_latency: assert property (
		sync_r > LAT + 1 && !dq_drive |-> term_on == $past(odt, LAT + 1))
		else $error("termination latency wrong");
	a_drive_no_term: assert property (dq_drive |-> !term_on)
		else $error("termination on while driving");
	a_termination_strobe_pair_term: assert property (
		termination_strobe_pair_term |-> term_on && mr1_r[MR1_STROBE_TERMINATION_ENABLE_BIT])
		else $error("strobe pair termination wrong");
	a_rtt_select: assert property (
		mr1_r == $past(mr1_r, 2) && mr2_r == $past(mr2_r, 2)
		|-> rtt_sel == (nom_on ? {mr1_r[9], mr1_r[6], mr1_r[2]} : {1'b0, mr2_r[10:9]}))
		else $error("resistance select wrong");
	a_odt_hold: assert property ($rose(odt) |-> odt[*4])
		else $error("odt dropped early");
	a_odt_hold_long: assert property (
		cke && cmd == CMD_WR && odt && addr[ADDR_BURST8_BIT] |-> odt[*6])
		else $error("odt dropped early after write");
	c_slow_pd: cover property ($rose(low_power) ##1 !dll_running);
	c_term_on: cover property ($rose(term_on));
	c_read: cover property (dq_drive);
	c_write_odt: cover property (cmd == CMD_WR && odt);
endmodule
`default_nettype wire

// [tb/ddrpd_bench.sv]
// Bench: AHB-Lite master on the controller end, DRAM end beside it,
// plus a second DRAM end driven directly for pin reset in power-down.
`timescale 1ns/100ps
`default_nettype none
module ddrpd_bench;
	import ddrpd_pkg::*;
	// WRITE_CAS_LATENCY 5 plus AL 0 minus 2
	localparam int LAT = 3;
	logic clock;
	logic arst_n;
	logic hsel;
	logic hwrite;
	logic hreadyout;
	logic [1:0] htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic low_power;
	logic dll_running;
	logic lp2;
	int errors;
	int n_compared;
	int n;
	int i;
	ddrpd_if lnk();
	ddrpd_if lnk2();
	// Short lock and busy counts keep the run brief
	ddrpd_ctrl #(.OP_BUSY(2), .DLL_LOCK_CYC(8)) ddrpd_ctrl_i (.clock(clock), .arst_n(arst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.lnk(lnk));
	ddrpd_device ddrpd_device_i (.clock(clock), .arst_n(arst_n), .lnk(lnk),
		.low_power(low_power), .dll_running(dll_running));
	ddrpd_device ddrpd_device_i2 (.clock(clock), .arst_n(arst_n), .lnk(lnk2),
		.low_power(lp2), .dll_running());
	ddrpd_assertions #(.LAT(LAT)) ddrpd_assertions_i (.clock(clock), .arst_n(arst_n),
		.cke(lnk.cke), .odt(lnk.odt), .reset_n(lnk.reset_n), .cmd(lnk.cmd), .bank(lnk.bank),
		.addr(lnk.addr), .term_on(lnk.term_on), .termination_strobe_pair_term(lnk.termination_strobe_pair_term),
		.dq_drive(lnk.dq_drive), .rtt_sel(lnk.rtt_sel), .low_power(low_power),
		.dll_running(dll_running));
	task complete_run;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Ready and data taken at the rising edge, before that edge's updates land
	task wait_rdy(output logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		while (hreadyout !== 1'b1 && k < 100) begin
			k++;
			@(posedge clock);
		end
		if (hreadyout !== 1'b1) begin
			errors++;
			complete_run;
		end
		d = hrdata;
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy(r);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy(r);
	endtask
	task poll(input logic [31:0] m, input logic [31:0] w, input string nm);
		int k;
		for (k = 0; k < 200; k++) begin
			ahb(1'b0, REG_STATUS, 32'h0, q);
			if ((q & m) === w) break;
		end
		check(nm, q & m, w);
		if ((q & m) !== w) complete_run;
	endtask
	task send(input ddrpd_cmd_t c, input logic [2:0] b, input logic [15:0] a);
		ahb(1'b1, REG_CMD, {a, 9'h000, b, c}, q);
		poll(32'h1, 32'h0, "pending");
	endtask
	task automatic wait_for(ref logic s, input logic v, input string nm);
		int k;
		for (k = 0; k < 400; k++) begin
			@(negedge clock);
			if (s === v) break;
		end
		check(nm, {31'h0, s}, {31'h0, v});
		if (s !== v) complete_run;
	endtask
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		errors = 0;
		n_compared = 0;
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		lnk2.cke = 1'b1;
		lnk2.odt = 1'b0;
		lnk2.reset_n = 1'b0;
		lnk2.cmd = CMD_NOP;
		lnk2.bank = 3'h0;
		lnk2.addr = 16'h0000;
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		ahb(1'b0, REG_STATUS, 32'h0, q);
		check("status after reset", q & 32'h0000_0006, 32'h0);
		ahb(1'b0, 8'h0C, 32'h0, q);
		check("unmapped read", q, 32'h0);
		// Nominal and strobe-pair termination on, fast precharge exit, DLL reset
		send(CMD_MRS, 3'h1, 16'h0804);
		send(CMD_MRS, 3'h2, 16'h0000);
		send(CMD_MRS, 3'h0, 16'h1100);
		poll(32'h4, 32'h4, "dll locked");
		ahb(1'b1, REG_CTRL, 32'h2, q);
		wait_for(lnk.odt, 1'b1, "odt raised");
		for (n = 0; n < 40 && lnk.term_on !== 1'b1; n++) @(negedge clock);
		check("odt latency", n, LAT + 1);
		check("strobe pair term", {31'h0, lnk.termination_strobe_pair_term}, 32'h1);
		check("resistance select", {29'h0, lnk.rtt_sel}, 32'h1);
		send(CMD_ACT, 3'h0, 16'h0000);
		ahb(1'b1, REG_CMD, {16'h0000, 9'h000, 3'h0, CMD_RD}, q);
		wait_for(lnk.dq_drive, 1'b1, "read drive");
		check("term while driving", {31'h0, lnk.term_on}, 32'h0);
		wait_for(lnk.term_on, 1'b1, "term after read");
		send(CMD_WR, 3'h0, 16'h1000);
		ahb(1'b1, REG_CTRL, 32'h0, q);
		wait_for(lnk.term_on, 1'b0, "term off");
		// Active, fast precharge, then slow precharge power-down
		for (i = 0; i < 3; i++) begin
			if (i == 1) send(CMD_PRE, 3'h0, 16'h0400);
			if (i == 2) send(CMD_MRS, 3'h0, 16'h0000);
			ahb(1'b1, REG_CTRL, 32'h1, q);
			wait_for(low_power, 1'b1, "pd entry");
			@(negedge clock);
			check("dll in pd", {31'h0, dll_running}, {31'h0, i < 2});
			check("cke in pd", {31'h0, lnk.cke}, 32'h0);
			ahb(1'b1, REG_CTRL, 32'h0, q);
			wait_for(low_power, 1'b0, "pd exit");
		end
		@(posedge clock);
		lnk2.reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		lnk2.cke <= 1'b0;
		wait_for(lp2, 1'b1, "second pd entry");
		@(posedge clock);
		lnk2.reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		check("pin reset in pd", {31'h0, lp2}, 32'h0);
		complete_run;
	end
endmodule
`default_nettype wire
